//--- design/cbc_balance.sv
// Cell balance controller with its register port.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cbc_map.svh"
module cbc_balance
   import cbc_pkg::*;
#(
   parameter int MAX_CELLS = 10,
   parameter int VW = 13,
   parameter int CYCLE_CLKS = `CBC_CYCLE_CLKS,
   parameter int MEAS_CLKS = `CBC_MEAS_CLKS,
   parameter int TO_BASE_TICKS = `CBC_TO_BASE_TICKS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [MAX_CELLS-1:0][VW-1:0] cell_sense_pin,
   input wire logic charger_present,
   input wire logic ov_present,
   input wire logic uv_present,
   output logic [MAX_CELLS-1:0] bleed
);
   localparam int IW = $clog2(MAX_CELLS);
   localparam int TW = $clog2(TO_BASE_TICKS * 8 + 1);
   localparam int CW = $clog2(CYCLE_CLKS);
   localparam int DW = $clog2(`CBC_DWELL_TICKS);

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   logic [1:0] en_q;
   logic [1:0] tsel_q;
   logic [3:0] thr_q;
   logic [3:0] ncell_q;
   logic to_en_q;
   logic [3:0] ov_dly_q;
   logic [7:0] uv_dly_q;
   logic [MAX_CELLS-1:0] bleed_q;
   logic [MAX_CELLS-1:0] sel_q;
   logic [IW-1:0] idx_q;
   logic meas_q;
   logic susp;
   logic started_q;
   logic expired_q;
   logic ov_done_q;
   logic uv_done_q;
   cbc_byte_t rdata_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         en_q <= 2'(`CBC_RST_BAL_CFG >> `CBC_EN_LSB);
         tsel_q <= 2'(`CBC_RST_BAL_CFG >> `CBC_TSEL_LSB);
         thr_q <= 4'(`CBC_RST_BAL_CFG >> `CBC_THR_LSB);
         ncell_q <= 4'(MAX_CELLS);
         to_en_q <= `CBC_RST_TO_EN;
         ov_dly_q <= 4'(`CBC_RST_DLY);
         uv_dly_q <= `CBC_RST_DLY;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `CBC_A_BAL_CFG: begin
               en_q <= reg_wdata[`CBC_EN_LSB +: 2];
               tsel_q <= reg_wdata[`CBC_TSEL_LSB +: 2];
               thr_q <= reg_wdata[`CBC_THR_LSB +: 4];
            end
            `CBC_A_PACK_CFG: begin
               ncell_q <= (reg_wdata[3:0] > 4'(MAX_CELLS)) ? 4'(MAX_CELLS) : reg_wdata[3:0];
               to_en_q <= reg_wdata[`CBC_TOEN_BIT];
            end
            `CBC_A_OV_DLY: ov_dly_q <= reg_wdata[3:0];
            `CBC_A_UV_DLY: uv_dly_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `CBC_A_BAL_CFG: rdata_q <= {en_q, tsel_q, thr_q};
            `CBC_A_PACK_CFG: rdata_q <= {3'h0, to_en_q, ncell_q};
            `CBC_A_OV_DLY: rdata_q <= {4'h0, ov_dly_q};
            `CBC_A_UV_DLY: rdata_q <= uv_dly_q;
            `CBC_A_STATUS: rdata_q <= {1'b0, uv_done_q, ov_done_q, expired_q,
                                      started_q, susp, meas_q, |bleed_q};
            `CBC_A_BLEED_IDX: rdata_q <= 8'(idx_q);
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // Measurement cycle
   // ----------------------------------------
   logic [CW-1:0] cyc_q;
   logic [CW-1:0] cyc_d;
   logic tick_p;
   logic meas_d;
   logic meas_end;

   assign tick_p = (cyc_q == CW'(CYCLE_CLKS - 1));
   assign cyc_d = tick_p ? '0 : cyc_q + 1'b1;
   assign meas_d = (cyc_d < CW'(MEAS_CLKS));
   assign meas_end = (cyc_q == CW'(MEAS_CLKS - 1));

   always_ff @(posedge clk) begin
      if (srst) begin
         cyc_q <= '0;
         meas_q <= 1'b1;
      end else begin
         cyc_q <= cyc_d;
         meas_q <= meas_d;
      end
   end

   // The results are taken at the close of the window, never while bleeding.
   logic [MAX_CELLS-1:0][VW-1:0] cell_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         cell_q <= '0;
      end else if (meas_end && !(|bleed_q)) begin
         cell_q <= cell_sense_pin;
      end
   end

   // ----------------------------------------
   // Highest cell and start threshold
   // ----------------------------------------
   logic [VW-1:0] max_v;
   logic [IW-1:0] max_i;
   logic [VW-1:0] thr_mv;
   logic above;

   always_comb begin
      max_v = '0;
      max_i = '0;
      for (int i = 0; i < MAX_CELLS; i++) begin
         if (i < int'(ncell_q) && cell_q[i] > max_v) begin
            max_v = cell_q[i];
            max_i = IW'(i);
         end
      end
   end

   assign thr_mv = VW'(`CBC_THR_TOP_MV - `CBC_THR_STEP_MV * int'(thr_q));
   assign above = (max_v > thr_mv);

   // ----------------------------------------
   // Dwell period and decision latch
   // ----------------------------------------
   logic [DW-1:0] dwell_q;
   logic latch_p;
   logic to_hit;

   assign latch_p = tick_p && (dwell_q == DW'(`CBC_DWELL_TICKS - 1));

   always_ff @(posedge clk) begin
      if (srst) begin
         dwell_q <= '0;
      end else if (latch_p) begin
         dwell_q <= '0;
      end else if (tick_p) begin
         dwell_q <= dwell_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sel_q <= '0;
         idx_q <= '0;
      end else if (to_en_q && (expired_q || to_hit)) begin
         sel_q <= '0;
      end else if (latch_p) begin
         sel_q <= above ? (MAX_CELLS'(1) << max_i) : '0;
         idx_q <= max_i;
      end
   end

   // ----------------------------------------
   // Balance time-out
   // ----------------------------------------
   logic [TW-1:0] to_cnt_q;
   logic [TW-1:0] to_lim;

   assign to_lim = TW'(TO_BASE_TICKS) << tsel_q;
   assign to_hit = started_q && !expired_q && tick_p && (to_cnt_q == to_lim - 1'b1);

   always_ff @(posedge clk) begin
      if (srst) begin
         started_q <= 1'b0;
      end else if (latch_p && above && to_en_q) begin
         started_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         to_cnt_q <= '0;
         expired_q <= 1'b0;
      end else if (to_en_q && to_hit) begin
         expired_q <= 1'b1;
      end else if (to_en_q && started_q && !expired_q && tick_p) begin
         to_cnt_q <= to_cnt_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Fault delay timing
   // ----------------------------------------
   logic [3:0] ov_lim;
   logic [7:0] uv_lim;
   logic [3:0] ov_cnt_q;
   logic [7:0] uv_cnt_q;

   always_comb begin
      ov_lim = ov_dly_q;
      if (ov_dly_q < 4'(`CBC_DLY_MIN_TICKS)) ov_lim = 4'(`CBC_DLY_MIN_TICKS);
      if (ov_dly_q > 4'(`CBC_OV_MAX_TICKS)) ov_lim = 4'(`CBC_OV_MAX_TICKS);
      uv_lim = uv_dly_q;
      if (uv_dly_q < 8'(`CBC_DLY_MIN_TICKS)) uv_lim = 8'(`CBC_DLY_MIN_TICKS);
      if (uv_dly_q > 8'(`CBC_UV_MAX_TICKS)) uv_lim = 8'(`CBC_UV_MAX_TICKS);
   end

   // Once a delay has run out the block balances again, whatever became of the fault.
   always_ff @(posedge clk) begin
      if (srst || !ov_present) begin
         ov_cnt_q <= '0;
         ov_done_q <= 1'b0;
      end else if (!ov_done_q && tick_p) begin
         ov_cnt_q <= ov_cnt_q + 1'b1;
         ov_done_q <= (ov_cnt_q == ov_lim - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !uv_present) begin
         uv_cnt_q <= '0;
         uv_done_q <= 1'b0;
      end else if (!uv_done_q && tick_p) begin
         uv_cnt_q <= uv_cnt_q + 1'b1;
         uv_done_q <= (uv_cnt_q == uv_lim - 1'b1);
      end
   end

   assign susp = (ov_present && !ov_done_q) || (uv_present && !uv_done_q);

   // ----------------------------------------
   // Bleed outputs
   // ----------------------------------------
   cbc_pol_e pol;
   logic allow;

   always_comb begin
      unique case (en_q)
         2'b00: pol = CBC_POL_OFF;
         2'b01: pol = CBC_POL_ALWAYS;
         default: pol = CBC_POL_CHARGER;
      endcase
   end

   // Charging is never held back here; the charge path is outside this block.
   assign allow = (pol == CBC_POL_ALWAYS
                   || (pol == CBC_POL_CHARGER && charger_present))
                  && !meas_d && !susp && !(to_en_q && expired_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         bleed_q <= '0;
      end else begin
         bleed_q <= allow ? sel_q : '0;
      end
   end
   assign bleed = bleed_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_one_bleed:
   assert property (@(posedge clk) disable iff (srst) $onehot0(bleed_q))
      else $error("More than one cell bleeding.");

   a_meas_quiet:
   assert property (@(posedge clk) disable iff (srst) meas_q |-> bleed_q == '0)
      else $error("Bleeding during measurement.");

   a_frozen_cells:
   assert property (@(posedge clk) disable iff (srst) (|bleed_q) |=> $stable(cell_q))
      else $error("Cell results changed while bleeding.");

   a_charger_loss:
   assert property (@(posedge clk) disable iff (srst)
      (pol == CBC_POL_CHARGER && !charger_present) |=> bleed_q == '0)
      else $error("Bleeding without charger.");

   a_disabled_off:
   assert property (@(posedge clk) disable iff (srst) (en_q == 2'b00) |=> bleed_q == '0)
      else $error("Bleeding while disabled.");

   a_expired_clear:
   assert property (@(posedge clk) disable iff (srst)
      (to_en_q && expired_q) |=> sel_q == '0 && bleed_q == '0)
      else $error("Decision kept after time-out.");

   a_fault_suspend:
   assert property (@(posedge clk) disable iff (srst)
      (ov_present && !ov_done_q) || (uv_present && !uv_done_q) |=> bleed_q == '0)
      else $error("Bleeding during fault timing.");

   a_dwell_latch:
   assert property (@(posedge clk) disable iff (srst)
      (sel_q != $past(sel_q)) |-> $past(latch_p) || $past(to_en_q && (expired_q || to_hit)))
      else $error("Decision changed between dwell points.");

   a_below_thr:
   assert property (@(posedge clk) disable iff (srst)
      (latch_p && !above && !expired_q) |=> sel_q == '0)
      else $error("Cell selected below threshold.");

   a_cell_range:
   assert property (@(posedge clk) disable iff (srst) (sel_q >> ncell_q) == '0)
      else $error("Cell beyond pack selected.");

   a_min_delay:
   assert property (@(posedge clk) disable iff (srst)
      ov_lim >= 4'h2 && uv_lim >= 8'h02 && ov_lim <= 4'h9 && uv_lim <= 8'h80)
      else $error("Fault delay outside its bounds.");

   a_timer_start:
   assert property (@(posedge clk) disable iff (srst)
      $rose(started_q) |-> $past(latch_p && above))
      else $error("Time-out started without a cell above threshold.");

   a_bleed_follows:
   assert property (@(posedge clk) disable iff (srst) (bleed_q & ~$past(sel_q)) == '0)
      else $error("Bleed output outside the latched decision.");
endmodule
`default_nettype wire

//--- design/cbc_map.svh
// Constants of the cell balance controller.
// Behaviour
// - Balance decision re-latched once per 7.5 minute dwell period only.
// - At latch, bleed highest cell if above start threshold, without hysteresis.
// - Never bleed more than one cell at a time.
// - After time-out expiry, clear and stop computing balance decisions.
// - Suppress bleeding: below threshold, expired, no charger under the charger policy, or measuring.
// - 250 ms cycle: 50 ms measuring with bleed off, 200 ms bleeding.
// - Stored cell voltages stay frozen while any bleed output is on.
// - Over- and undervoltage delays are never shorter than 500 ms.
// - Suspend bleeding while OV or UV delay runs; at most 2.25/32 s.
// - Resume balancing once fault timing completes, latched or cleared.
// - Two-bit time-out field selects 1, 2, 4 or 8 hours.
// - Time-out count starts when first cell exceeds start threshold.
// - Bleeding stops at once when the charger is lost under the charger policy.
// - Four-bit threshold: 3.9 V down to 2.4 V, 0.1 V steps, default 3.9 V.
// - Policies: balance always, only with charger, or never.
// - Balance enable field of zero disables balancing entirely.
// - Own start-threshold comparison, separate from overvoltage trip.
// - Balancing runs alongside charging without holding the charge path.
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH
`define CBC_CLK_HZ 40000000
`define CBC_CYCLE_MS 250
`define CBC_MEAS_MS 50
`define CBC_CYCLE_CLKS (`CBC_CLK_HZ / 1000 * `CBC_CYCLE_MS)
`define CBC_MEAS_CLKS (`CBC_CLK_HZ / 1000 * `CBC_MEAS_MS)
`define CBC_DWELL_MIN_X10 75
`define CBC_DWELL_TICKS (`CBC_DWELL_MIN_X10 * 6000 / `CBC_CYCLE_MS)
`define CBC_TO_BASE_H 1
`define CBC_TO_BASE_TICKS (`CBC_TO_BASE_H * 3600000 / `CBC_CYCLE_MS)
`define CBC_DLY_MIN_MS 500
`define CBC_OV_MAX_MS 2250
`define CBC_UV_MAX_MS 32000
`define CBC_DLY_MIN_TICKS (`CBC_DLY_MIN_MS / `CBC_CYCLE_MS)
`define CBC_OV_MAX_TICKS (`CBC_OV_MAX_MS / `CBC_CYCLE_MS)
`define CBC_UV_MAX_TICKS (`CBC_UV_MAX_MS / `CBC_CYCLE_MS)
`define CBC_THR_TOP_MV 3900
`define CBC_THR_STEP_MV 100
`define CBC_A_BAL_CFG 4'h0
`define CBC_A_PACK_CFG 4'h1
`define CBC_A_OV_DLY 4'h2
`define CBC_A_UV_DLY 4'h3
`define CBC_A_STATUS 4'h4
`define CBC_A_BLEED_IDX 4'h5
`define CBC_RST_BAL_CFG 8'h40
`define CBC_RST_TO_EN 1'b1
`define CBC_RST_DLY 8'h02
`define CBC_EN_LSB 6
`define CBC_TSEL_LSB 4
`define CBC_THR_LSB 0
`define CBC_TOEN_BIT 4
`endif

//--- design/cbc_pkg.sv
// Types of the cell balance controller.
package cbc_pkg;
   typedef enum logic [1:0] {
      CBC_POL_OFF,
      CBC_POL_ALWAYS,
      CBC_POL_CHARGER
   } cbc_pol_e;
   typedef logic [7:0] cbc_byte_t;
endpackage

//--- test/cbc_cell_stack.sv
// Behavioural model of the series cell stack and the charger detector.
`timescale 1ns/1ps
`default_nettype none
module cbc_cell_stack #(
   parameter int N = 10,
   parameter int VW = 13
) (
   input wire logic clk,
   input wire logic [N-1:0] bleed,
   input wire logic chg_on,
   output logic [N-1:0][VW-1:0] cell_sense_pin,
   output logic charger_present
);
   logic [VW-1:0] mv [N];
   int drain;
   initial begin
      for (int i = 0; i < N; i++) begin
         mv[i] = 13'h0ED8;
      end
      mv[3] = 13'h0F6E;
      mv[N-1] = 13'h0FA0;
      drain = 0;
   end
   // A bled cell loses charge slowly, one millivolt per 1024 cycles of bleeding.
   always @(posedge clk) begin
      if (bleed != '0) begin
         drain <= drain + 1;
         for (int i = 0; i < N; i++) begin
            if (bleed[i] && drain % 1024 == 1023) begin
               mv[i] <= mv[i] - 1'b1;
            end
         end
      end
   end
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cell_sense_pin[i] = mv[i];
      end
   end
   assign charger_present = chg_on;
endmodule
`default_nettype wire

//--- test/test_cbc_balance.sv
// Self-checking testbench of the cell balance controller.
`timescale 1ns/1ps
`default_nettype none
module test_cbc_balance;
   localparam int CYC = 30;
   localparam int MEAS = 6;
   localparam int LATCH = 1800;
   localparam logic [7:0] RST [5] = '{8'h40, 8'h1A, 8'h02, 8'h02, 8'h00};
   localparam logic [7:0] POL [4] = '{8'h30, 8'hB0, 8'hF0, 8'h70};
   logic clk;
   logic srst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [9:0][12:0] cells;
   logic charger_present;
   logic chg_on;
   logic ov_present;
   logic uv_present;
   logic [9:0] bleed;
   logic pre_bleed = 1'b0;
   logic [7:0] rv;
   int ph = 0;
   int ticks = 0;
   int err_count = 0;
   int cmp_count = 0;

   cbc_balance #(.CYCLE_CLKS(CYC), .MEAS_CLKS(MEAS), .TO_BASE_TICKS(4)) dut (
      .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cell_sense_pin(cells),
      .charger_present(charger_present), .ov_present(ov_present),
      .uv_present(uv_present), .bleed(bleed));
   cbc_cell_stack stack (.clk(clk), .bleed(bleed), .chg_on(chg_on), .cell_sense_pin(cells),
      .charger_present(charger_present));

   // Mirrors the cycle phase and tick count, and watches the measurement slot.
   always @(posedge clk) begin
      if (srst) begin
         ph <= 0;
         ticks <= 0;
      end else begin
         ph <= (ph == CYC - 1) ? 0 : ph + 1;
         if (ph == CYC - 1) ticks <= ticks + 1;
         if (ticks < LATCH && bleed !== 10'h000) pre_bleed <= 1'b1;
         if (ph >= 1 && ph < MEAS && bleed !== 10'h000) begin
            err_count++;
            $display("unexpected at %0t: bleed during measurement", $time);
         end
      end
   end

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic hang;
      err_count++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic at_phase(input int p);
      for (int n = 0; n < 2 * CYC; n++) begin
         @(posedge clk);
         #1;
         if (ph == p) break;
      end
      if (ph != p) hang();
   endtask
   task automatic to_tick(input int t);
      for (int n = 0; n < 70000; n++) begin
         @(posedge clk);
         #1;
         if (ticks >= t) break;
      end
      if (ticks < t) hang();
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      srst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ov_present = 1'b0;
      uv_present = 1'b0;
      chg_on = 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk(bleed, 10'h000);
      for (int i = 0; i < 5; i++) begin
         rd((i == 4) ? 4'hF : 4'(i), rv);
         chk(rv, RST[i]);
      end
      // Eight cells with the time-out on; the highest cell sits beyond them.
      wr(4'h1, 8'h18);
      wr(4'h0, 8'h70);
      to_tick(LATCH);
      chk(pre_bleed, 1'b0);
      at_phase(MEAS + 3);
      chk(bleed, 10'h008);
      wr(4'h5, 8'hFF);
      rd(4'h5, rv);
      chk(rv, 8'h03);
      rd(4'h4, rv);
      chk(rv & 8'h19, 8'h09);
      wr(4'h0, 8'hB0);
      at_phase(MEAS + 3);
      chk(bleed, 10'h008);
      @(posedge clk);
      chg_on <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      #1;
      chk(bleed, 10'h000);
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, POL[i]);
         at_phase(MEAS + 3);
         chk(bleed, (i == 3) ? 10'h008 : 10'h000);
      end
      @(posedge clk);
      chg_on <= 1'b1;
      // A zero delay is written; the suspension must still last two ticks.
      for (int f = 0; f < 2; f++) begin
         wr(4'(2 + f), 8'h00);
         at_phase(MEAS + 3);
         @(posedge clk);
         if (f == 0) begin
            ov_present <= 1'b1;
         end else begin
            uv_present <= 1'b1;
         end
         @(posedge clk);
         @(posedge clk);
         #1;
         chk(bleed, 10'h000);
         rd(4'h4, rv);
         chk(rv & 8'h04, 8'h04);
         at_phase(MEAS + 3);
         chk(bleed, 10'h000);
         to_tick(ticks + 2);
         at_phase(MEAS + 3);
         chk(bleed, 10'h008);
         rd(4'h4, rv);
         chk(rv & 8'h64, (f == 0) ? 8'h20 : 8'h40);
         @(posedge clk);
         ov_present <= 1'b0;
         uv_present <= 1'b0;
      end
      // Eight hours are 32 ticks from the latch; the last bleeding tick is the 31st.
      to_tick(LATCH + 31);
      at_phase(MEAS + 3);
      chk(bleed, 10'h008);
      to_tick(LATCH + 32);
      at_phase(MEAS + 3);
      chk(bleed, 10'h000);
      rd(4'h4, rv);
      chk(rv & 8'h10, 8'h10);
      close_out();
   end
endmodule
`default_nettype wire
